// *** rtl/timer8_pkg.sv ***
// Behaviour
// - Clock select picks tick source; zero stops.
// - Each tick clears, increments or decrements counter.
// - CPU count write beats clear or count.
// - Waveform mode sets sequence and overflow point.
// - Equality sets match flag one tick later.
// - Enabled flag requests interrupt; cleared by ack.
// - PWM modes double buffer compare at top.
// - CPU compare writes go to buffer when buffered.
// - Force strobe acts like match, non-PWM only.
// - Count write blocks match on next tick.
// - Output state survives mode change; reset zero.
// - Action bits unbuffered, apply at next match.
// - Nonzero action bits override port data.
// - Action zero leaves output state unchanged.
// - Action bits: set/clear/toggle or PWM polarity.
// - Normal mode counts up, wraps FF to 00.
// - Normal overflow flag set when count becomes zero.
// - Overflow interrupt execution clears overflow flag.
// - Bottom is 00, max FF, top per mode.
// - Clear-on-match mode clears counter at match.
package timer8_pkg;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;
   localparam logic [7:0] MAX_VAL = 8'hFF;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PHASE_PWM = 2'h1;
   localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
   localparam logic [1:0] WGM_FAST_PWM = 2'h3;
   localparam logic [1:0] COM_NONE = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   localparam logic [2:0] CS_STOPPED = 3'h0;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
endpackage

// *** rtl/tick_source.sv ***
// Selects the timer tick from a prescaler tap or a synchronised external pin edge.
module tick_source
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Selection
   input wire logic [2:0] clock_source_select,
   input wire logic [4:0] prescale_taps,
   input wire logic ext_pin,
   // Result
   output logic timer_tick
);
   logic ext_meta_reg;
   logic ext_sync_reg;
   logic ext_last_reg;
   logic tick_next;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_last_reg <= 1'b0;
      end else begin
         ext_meta_reg <= ext_pin;
         ext_sync_reg <= ext_meta_reg;
         ext_last_reg <= ext_sync_reg;
      end
   end

   always_comb begin
      case (clock_source_select)
         CS_STOPPED: tick_next = 1'b0;
         CS_EXT_FALL: tick_next = ext_last_reg & ~ext_sync_reg;
         CS_EXT_RISE: tick_next = ~ext_last_reg & ext_sync_reg;
         default: tick_next = prescale_taps[3'(clock_source_select - 3'h1)];
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_tick <= 1'b0;
      end else begin
         timer_tick <= tick_next;
      end
   end
endmodule

// *** rtl/timer8_compare_unit.sv ***
// Eight-bit up/down timer with one output compare unit. CPU accesses are one-cycle strobes.
module timer8_compare_unit
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Tick sources
   input wire logic [2:0] clock_source_select,
   input wire logic [4:0] prescale_taps,
   input wire logic ext_pin,
   // Control
   input wire logic [1:0] waveform_mode,
   input wire logic [1:0] output_action_bits,
   input wire logic force_compare_strobe,
   input wire logic compare_irq_enable,
   input wire logic overflow_irq_enable,
   input wire logic global_irq_enable,
   // Count value access
   input wire logic count_write,
   input wire logic [7:0] count_wdata,
   output logic [7:0] count_value,
   // Compare value access
   input wire logic compare_write,
   input wire logic [7:0] compare_wdata,
   output logic [7:0] compare_value,
   // Flags
   input wire logic compare_flag_clear,
   input wire logic compare_irq_ack,
   input wire logic overflow_flag_clear,
   input wire logic overflow_irq_ack,
   output logic compare_match_flag,
   output logic overflow_flag,
   output logic compare_irq,
   output logic overflow_irq,
   // Pin
   input wire logic port_data,
   input wire logic output_pin_direction,
   output logic pin_out,
   output logic pin_oe,
   output logic compare_output
);
   logic timer_tick;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [7:0] ocr_reg;
   logic [7:0] ocr_buf_reg;
   logic down_reg;
   logic down_next;
   logic block_reg;
   logic oc_reg;
   logic oc_next;
   logic ocf_reg;
   logic tov_reg;
   logic match;
   logic match_eff;
   logic is_pwm;
   logic at_top;
   logic at_bottom;
   logic update_point;
   logic tov_set;
   logic [7:0] ocr_visible;

   tick_source u_tick (
      .clk(clk),
      .arst_n(arst_n),
      .clock_source_select(clock_source_select),
      .prescale_taps(prescale_taps),
      .ext_pin(ext_pin),
      .timer_tick(timer_tick)
   );

   assign is_pwm = (waveform_mode == WGM_PHASE_PWM) || (waveform_mode == WGM_FAST_PWM);
   assign match = (count_reg == ocr_reg);
   assign match_eff = timer_tick & match & ~block_reg;
   assign at_top = (count_reg == MAX_VAL);
   assign at_bottom = (count_reg == BOTTOM_VAL);

   // Counting sequence per mode.
   always_comb begin
      count_next = count_reg;
      down_next = down_reg;
      case (waveform_mode)
         WGM_NORMAL: count_next = count_reg + 8'h01;
         WGM_CLEAR_ON_MATCH: begin
            if (match) begin
               count_next = BOTTOM_VAL;
            end else begin
               count_next = count_reg + 8'h01;
            end
         end
         WGM_FAST_PWM: count_next = count_reg + 8'h01;
         WGM_PHASE_PWM: begin
            if (at_top) begin
               down_next = 1'b1;
               count_next = count_reg - 8'h01;
            end else if (at_bottom) begin
               down_next = 1'b0;
               count_next = count_reg + 8'h01;
            end else if (down_reg) begin
               count_next = count_reg - 8'h01;
            end else begin
               count_next = count_reg + 8'h01;
            end
         end
         default: count_next = count_reg;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= COUNT_RESET;
         down_reg <= 1'b0;
      end else if (count_write) begin
         count_reg <= count_wdata;
      end else if (timer_tick) begin
         count_reg <= count_next;
         down_reg <= down_next;
      end
   end

   // A count write blocks matches until the next tick has passed.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         block_reg <= 1'b0;
      end else if (count_write) begin
         block_reg <= 1'b1;
      end else if (timer_tick) begin
         block_reg <= 1'b0;
      end
   end

   // Buffer update point: top for fast PWM, top for phase correct.
   assign update_point = timer_tick && ((waveform_mode == WGM_FAST_PWM) ? at_top : at_top && !down_reg);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ocr_reg <= COMPARE_RESET;
         ocr_buf_reg <= COMPARE_RESET;
      end else begin
         if (compare_write) begin
            ocr_buf_reg <= compare_wdata;
         end
         if (!is_pwm) begin
            if (compare_write) begin
               ocr_reg <= compare_wdata;
            end
         end else if (update_point) begin
            ocr_reg <= ocr_buf_reg;
         end
      end
   end

   assign ocr_visible = is_pwm ? ocr_buf_reg : ocr_reg;

   // Output compare state.
   always_comb begin
      oc_next = oc_reg;
      if (!is_pwm) begin
         if (match_eff || force_compare_strobe) begin
            case (output_action_bits)
               COM_NONE: oc_next = oc_reg;
               COM_TOGGLE: oc_next = ~oc_reg;
               COM_CLEAR: oc_next = 1'b0;
               COM_SET: oc_next = 1'b1;
               default: oc_next = oc_reg;
            endcase
         end
      end else if (output_action_bits[1]) begin
         if (match_eff) begin
            if (waveform_mode == WGM_FAST_PWM || !down_reg) begin
               oc_next = output_action_bits[0];
            end else begin
               oc_next = ~output_action_bits[0];
            end
         end else if (timer_tick && waveform_mode == WGM_FAST_PWM && at_top) begin
            oc_next = ~output_action_bits[0];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oc_reg <= 1'b0;
      end else begin
         oc_reg <= oc_next;
      end
   end

   // Flags: hardware set wins over clear.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ocf_reg <= 1'b0;
      end else if (match_eff) begin
         ocf_reg <= 1'b1;
      end else if (compare_flag_clear || compare_irq_ack) begin
         ocf_reg <= 1'b0;
      end
   end

   always_comb begin
      case (waveform_mode)
         WGM_NORMAL, WGM_CLEAR_ON_MATCH: tov_set = at_top && count_next == BOTTOM_VAL;
         WGM_FAST_PWM: tov_set = at_top;
         WGM_PHASE_PWM: tov_set = at_bottom;
         default: tov_set = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tov_reg <= 1'b0;
      end else if (timer_tick && !count_write && tov_set) begin
         tov_reg <= 1'b1;
      end else if (overflow_flag_clear || overflow_irq_ack) begin
         tov_reg <= 1'b0;
      end
   end

   // Registered outputs.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_value <= COUNT_RESET;
         compare_value <= COMPARE_RESET;
         compare_match_flag <= 1'b0;
         overflow_flag <= 1'b0;
         compare_irq <= 1'b0;
         overflow_irq <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         compare_output <= 1'b0;
      end else begin
         count_value <= count_reg;
         compare_value <= ocr_visible;
         compare_match_flag <= ocf_reg;
         overflow_flag <= tov_reg;
         compare_irq <= ocf_reg & compare_irq_enable & global_irq_enable;
         overflow_irq <= tov_reg & overflow_irq_enable & global_irq_enable;
         pin_out <= (output_action_bits != COM_NONE) ? oc_reg : port_data;
         pin_oe <= output_pin_direction;
         compare_output <= oc_reg;
      end
   end
endmodule

// *** verification/pin_pad_model.sv ***
// Port pad with a pull-up, as seen by the rest of the board.
module pin_pad_model (
   // Driver side
   input wire logic pin_out,
   input wire logic pin_oe,
   // Pad
   output logic pad
);
   timeunit 1ns;
   timeprecision 100ps;
   assign pad = pin_oe ? pin_out : 1'b1;
endmodule

// *** verification/timer8_props.sv ***
module timer8_chk
   import timer8_pkg::*;
(
   // Clock and controls
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] clock_source_select,
   input wire logic [1:0] waveform_mode,
   input wire logic [1:0] output_action_bits,
   input wire logic compare_irq_enable,
   input wire logic overflow_irq_enable,
   input wire logic global_irq_enable,
   input wire logic count_write,
   input wire logic [7:0] count_wdata,
   input wire logic compare_write,
   input wire logic [7:0] compare_wdata,
   input wire logic compare_flag_clear,
   input wire logic compare_irq_ack,
   input wire logic port_data,
   input wire logic output_pin_direction,
   // Results
   input wire logic [7:0] count_value,
   input wire logic [7:0] compare_value,
   input wire logic compare_match_flag,
   input wire logic overflow_flag,
   input wire logic compare_irq,
   input wire logic overflow_irq,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic compare_output
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   chk_irq_cmp: assert property (compare_irq == (compare_match_flag && $past(compare_irq_enable) && $past(global_irq_enable)))
      else $error("compare irq wrong");
   chk_irq_ovf: assert property (overflow_irq == (overflow_flag && $past(overflow_irq_enable) && $past(global_irq_enable)))
      else $error("overflow irq wrong");
   chk_pin_dir: assert property ($past(arst_n) |-> pin_oe == $past(output_pin_direction))
      else $error("pin direction wrong");
   chk_pin_port: assert property ($past(arst_n) && $past(output_action_bits) == COM_NONE |-> pin_out == $past(port_data))
      else $error("port data not on pin");
   chk_pin_oc: assert property ($past(output_action_bits) != COM_NONE |-> pin_out == compare_output)
      else $error("compare output not on pin");
   chk_stop_hold: assert property ((clock_source_select == CS_STOPPED && !count_write)[*3] |=> $stable(count_value))
      else $error("stopped counter moved");
   chk_count_wr: assert property (count_write |=> ##1 count_value == $past(count_wdata, 2))
      else $error("count write lost");
   chk_cmp_wr: assert property (compare_write ##1 (!compare_write && $stable(waveform_mode)) |=> compare_value == $past(compare_wdata, 2))
      else $error("compare write lost");
   chk_flag_hold: assert property (compare_match_flag && !compare_flag_clear && !compare_irq_ack && !$past(compare_flag_clear) && !$past(compare_irq_ack) |=> compare_match_flag)
      else $error("match flag dropped");
endmodule
bind timer8_compare_unit timer8_chk i_chk (.clk, .arst_n, .clock_source_select, .waveform_mode, .output_action_bits,
   .compare_irq_enable, .overflow_irq_enable, .global_irq_enable, .count_write, .count_wdata, .compare_write,
   .compare_wdata, .compare_flag_clear, .compare_irq_ack, .port_data, .output_pin_direction, .count_value,
   .compare_value, .compare_match_flag, .overflow_flag, .compare_irq, .overflow_irq, .pin_out, .pin_oe, .compare_output);

// *** verification/testbench.sv ***
module testbench;
   import timer8_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [2:0] sel; logic [1:0] mode; logic [1:0] act; logic [7:0] cmp; logic [7:0] start;
      int n; logic [7:0] cnt; logic mf; logic ov; logic oc;} row_t;
   logic clk = 0, arst_n = 0, ext_pin = 0, force_compare_strobe = 0, count_write = 0, compare_write = 0;
   logic [2:0] clock_source_select = 0;
   logic [4:0] prescale_taps = 0;
   logic [1:0] waveform_mode = 0, output_action_bits = 0;
   logic compare_irq_enable = 1, overflow_irq_enable = 1, global_irq_enable = 1;
   logic [7:0] count_wdata = 0, compare_wdata = 0, count_value, compare_value;
   logic compare_flag_clear = 0, compare_irq_ack = 0, overflow_flag_clear = 0, overflow_irq_ack = 0;
   logic compare_match_flag, overflow_flag, compare_irq, overflow_irq;
   logic port_data = 0, output_pin_direction = 0, pin_out, pin_oe, compare_output, pad;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   row_t rows [7] = '{
      '{1, 0, 0, 8'h10, 8'hFE, 2, 8'h00, 0, 1, 0},
      '{1, 0, 1, 8'h05, 8'h04, 3, 8'h07, 1, 0, 1},
      '{1, 2, 2, 8'h03, 8'h01, 3, 8'h00, 1, 0, 0},
      '{1, 0, 1, 8'h07, 8'h07, 1, 8'h08, 0, 0, 0},
      '{0, 0, 1, 8'h20, 8'h20, 2, 8'h20, 0, 0, 0},
      '{1, 1, 0, 8'h80, 8'hFE, 3, 8'hFD, 0, 0, 0},
      '{1, 3, 0, 8'h90, 8'hFE, 3, 8'h01, 0, 1, 0}
   };
   timer8_compare_unit i_timer8_compare_unit (.clk, .arst_n, .clock_source_select, .prescale_taps, .ext_pin,
      .waveform_mode, .output_action_bits, .force_compare_strobe, .compare_irq_enable, .overflow_irq_enable,
      .global_irq_enable, .count_write, .count_wdata, .count_value, .compare_write, .compare_wdata, .compare_value,
      .compare_flag_clear, .compare_irq_ack, .overflow_flag_clear, .overflow_irq_ack, .compare_match_flag,
      .overflow_flag, .compare_irq, .overflow_irq, .port_data, .output_pin_direction, .pin_out, .pin_oe,
      .compare_output);
   pin_pad_model i_pin_pad_model (.pin_out, .pin_oe, .pad);
   always #5 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task test_done();
      if (n_mismatch == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         test_done();
      end
   end
   // Pulses one strobe for a single cycle, then lets the result settle.
   // 0 is the overflow acknowledge, 1 the compare acknowledge, 2 the force strobe.
   task automatic pulse(input int which);
      @(posedge clk);
      case (which)
         0: overflow_irq_ack <= 1;
         1: compare_irq_ack <= 1;
         default: force_compare_strobe <= 1;
      endcase
      @(posedge clk);
      overflow_irq_ack <= 0;
      compare_irq_ack <= 0;
      force_compare_strobe <= 0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic run_row(input row_t r);
      @(posedge clk);
      clock_source_select <= r.sel;
      waveform_mode <= r.mode;
      output_action_bits <= r.act;
      compare_flag_clear <= 1;
      overflow_flag_clear <= 1;
      @(posedge clk);
      compare_flag_clear <= 0;
      overflow_flag_clear <= 0;
      compare_write <= 1;
      compare_wdata <= r.cmp;
      @(posedge clk);
      compare_write <= 0;
      count_write <= 1;
      count_wdata <= r.start;
      @(posedge clk);
      count_write <= 0;
      repeat (r.n) begin
         @(posedge clk);
         prescale_taps <= 5'h01;
         @(posedge clk);
         prescale_taps <= 5'h00;
      end
      repeat (4) @(posedge clk);
      #1;
      chk(count_value, r.cnt);
      chk(compare_value, r.cmp);
      chk1(compare_match_flag, r.mf);
      chk1(compare_irq, r.mf);
      chk1(overflow_flag, r.ov);
      chk1(overflow_irq, r.ov);
      chk1(compare_output, r.oc);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      #1;
      chk1(compare_output, 0);
      chk(count_value, 8'h00);
      foreach (rows[i]) run_row(rows[i]);
      pulse(0);
      chk1(overflow_flag, 0);
      chk1(overflow_irq, 0);
      run_row(rows[1]);
      pulse(1);
      chk1(compare_match_flag, 0);
      clock_source_select <= CS_STOPPED;
      output_action_bits <= COM_CLEAR;
      pulse(2);
      chk1(compare_output, 0);
      chk1(compare_match_flag, 0);
      output_pin_direction <= 1;
      waveform_mode <= WGM_FAST_PWM;
      output_action_bits <= COM_SET;
      pulse(2);
      chk1(compare_output, 0);
      chk1(pin_oe, 1);
      chk1(pad, 0);
      output_action_bits <= COM_NONE;
      port_data <= 1;
      repeat (3) @(posedge clk);
      #1;
      chk1(pad, 1);
      waveform_mode <= WGM_NORMAL;
      output_action_bits <= COM_SET;
      pulse(2);
      chk1(pin_out, 1);
      arst_n <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk1(compare_output, 0);
      arst_n <= 1;
      test_done();
   end
endmodule
